// ===== audio_ctrl_bank.sv
// Control and status register bank of the multichannel audio processor
`timescale 1ns/1ps
`include "audio_ctrl_regs.svh"
//
// How it works
// - Tone holds bass and treble 4-bit codes
// - All-ones code bypasses band; reset bypasses both
// - Bass centered 160Hz, treble 5kHz
// - Tone applies to front left/right only
// - Link shutdown forces link low until reset
// - Clock powerdown stops internal clock only
// - DSP powerdown sequence precedes clock stop
// - Amplifier powerdown bit requests DSP fade-out
// - Powerdown writes force low nibble 1110
// - Extended feature ID register is read-only, fixed except bit 14
// - Identity bit 14 follows address select
// - Variable-rate enable bit selects the programmed rate, else a fixed 48 kHz; rate registers take writes either way
// - Double-rate enable doubles programmed rate when variable rate is enabled
// - Readiness bits always store 0111
// - Front rate rounds to nearest supported rate
// - Surround and LFE rates mirror front
// - Resets load 48 kHz into rates
// - Channel volume codes are attenuation only
// - Per-channel mutes; reset zero attenuation muted
// - Compliance mode six bits, else up to 68h
// - Words accessed as high then low byte

module audio_ctrl_bank
  import audio_ctrl_pkg::*;
#(
  parameter logic [15:0] RESET_REG_ID = 16'h0042  // Arbitrary part code
) (
  // Clock and resets
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        warm_rst_in,
  // Byte register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic      [7:0]  reg_rdata_out,
  output logic             reg_rvalid_out,
  // Pins and mode inputs
  input  wire logic        address_select_pin_in,
  input  wire logic        full_compliance_in,
  input  wire logic        dsp_pd_done_in,
  // Tone controls
  output logic signed [4:0] bass_gain_db_out,
  output logic             bass_bypass_out,
  output logic signed [4:0] treble_gain_db_out,
  output logic             treble_bypass_out,
  output logic      [5:0]  tone_channel_mask_out,
  // Power control
  output logic             link_hold_low_out,
  output logic             dsp_pd_req_out,
  output logic             clk_stop_out,
  output logic             amp_fade_req_out,
  // Rate control
  output logic             variable_rate_enable_out,
  output logic             double_rate_enable_out,
  output logic      [16:0] sample_rate_out,
  // Additional channel volume: center, lfe, right surround, left surround
  output logic      [27:0] chan_atten_out,
  output logic      [3:0]  chan_mute_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [1:0]  sel_sync_q, sel_sync_d;
  logic [15:0] tone_q, tone_d, pd_q, pd_d;
  logic [15:0] ext_q, ext_d, rate_q, rate_d;
  logic [15:0] vol_a_q, vol_a_d, vol_b_q, vol_b_d;
  logic        link_shut_q, link_shut_d;
  logic [7:0]  hold_q, hold_d;
  logic [6:0]  hold_addr_q, hold_addr_d;
  logic        hold_vld_q, hold_vld_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;
  pd_state_t   pd_state_q, pd_state_d;
  logic signed [4:0] bass_q, bass_d, treble_q, treble_d;
  logic        bass_byp_q, bass_byp_d, treble_byp_q, treble_byp_d;
  logic        stop_q, stop_d;
  logic [16:0] eff_rate_q, eff_rate_d;
  logic [5:0]  mask_q;
  logic        commit, soft_rst, bank_rst;
  logic [7:0]  word_addr;
  logic [15:0] word_cur, word_new, rd_word;

  // Tone code to gain in whole dB; codes 5 to 9 step by 1dB
  function automatic logic signed [4:0] tone_gain(input logic [3:0] code);
    unique case (code)
      4'h0:    tone_gain = 5'sd12;
      4'h1:    tone_gain = 5'sd10;
      4'h2:    tone_gain = 5'sd8;
      4'h3:    tone_gain = 5'sd6;
      4'h4:    tone_gain = 5'sd4;
      4'h5:    tone_gain = 5'sd2;
      4'h6:    tone_gain = 5'sd1;
      4'h7:    tone_gain = 5'sd0;
      4'h8:    tone_gain = -5'sd1;
      4'h9:    tone_gain = -5'sd2;
      4'hA:    tone_gain = -5'sd4;
      4'hB:    tone_gain = -5'sd6;
      4'hC:    tone_gain = -5'sd8;
      4'hD:    tone_gain = -5'sd10;
      4'hE:    tone_gain = -5'sd12;
      default: tone_gain = 5'sd0;
    endcase
  endfunction

  // Nearest supported rate; the midpoint itself goes up to 48k
  function automatic logic [15:0] round_rate(input logic [15:0] value);
    round_rate = (value >= `RATE_MIDPOINT) ? `RATE_48K : `RATE_44K1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Byte pairing and register reads

  assign word_addr = {reg_addr_in[7:1], 1'b0};
  assign commit    = reg_wr_in & reg_addr_in[0];
  assign soft_rst  = reg_wr_in & (word_addr == `OFS_REG_RESET);
  assign bank_rst  = rst_in | warm_rst_in | soft_rst;

  // Current word, as software reads it back
  always_comb begin
    rd_word = 16'h0000;
    unique case (word_addr)
      `OFS_REG_RESET:      rd_word = RESET_REG_ID;
      `OFS_TONE:           rd_word = tone_q;
      `OFS_POWERDOWN:      rd_word = {pd_q[15:13], link_shut_q, pd_q[11:0]};
      `OFS_EXT_ID:         rd_word = `EXT_ID_FIXED | (16'(sel_sync_q[1]) << `EXT_ID_SELECT_BIT);
      `OFS_EXT_STATUS:     rd_word = ext_q;
      `OFS_RATE_FRONT,
      `OFS_RATE_SURROUND,
      `OFS_RATE_LFE:       rd_word = rate_q;
      `OFS_RATE_CONV_A,
      `OFS_RATE_CONV_B:    rd_word = `RATE_48K;
      `OFS_VOL_CENTER_LFE: rd_word = vol_a_q;
      `OFS_VOL_REAR:       rd_word = vol_b_q;
      default:             rd_word = 16'h0000;      // Unmapped reads as zero
    endcase
  end

  // An unpaired low byte keeps the register's present high byte
  assign word_cur = rd_word;
  assign word_new = {(hold_vld_q && hold_addr_q == word_addr[7:1]) ? hold_q : word_cur[15:8],
                     reg_wdata_in};

  ////////////////////////////////////////////////////////////////////////////
  // Register next state

  always_comb begin
    sel_sync_d  = {sel_sync_q[0], address_select_pin_in};
    tone_d      = tone_q;
    pd_d        = pd_q;
    ext_d       = ext_q;
    rate_d      = rate_q;
    vol_a_d     = vol_a_q;
    vol_b_d     = vol_b_q;
    link_shut_d = link_shut_q;
    hold_d      = hold_q;
    hold_addr_d = hold_addr_q;
    hold_vld_d  = hold_vld_q;
    rdata_d     = reg_addr_in[0] ? rd_word[7:0] : rd_word[15:8];
    rvalid_d    = reg_rd_in;
    if (reg_wr_in && !reg_addr_in[0]) begin
      hold_d      = reg_wdata_in;             // High byte waits for its partner
      hold_addr_d = reg_addr_in[7:1];
      hold_vld_d  = 1'b1;
    end else if (commit) begin
      hold_vld_d  = 1'b0;
      unique case (word_addr)
        `OFS_TONE:           tone_d = word_new & `TONE_VALID_MASK;
        `OFS_POWERDOWN: begin
          pd_d = {word_new[15:4], `PD_FORCED_NIBBLE};
          if (word_new[`PD_LINK_SHUT_BIT]) begin
            link_shut_d = 1'b1;
          end
        end
        `OFS_EXT_STATUS:     ext_d = (word_new & ~`EXT_READY_MASK) | `EXT_READY_VALUE;
        `OFS_RATE_FRONT:     rate_d = round_rate(word_new);
        `OFS_VOL_CENTER_LFE: vol_a_d = word_new;
        `OFS_VOL_REAR:       vol_b_d = word_new;
        default:             hold_vld_d = 1'b0;       // Read-only or unmapped words ignore writes
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    sel_sync_q <= sel_sync_d;
    rdata_q    <= rdata_d;
    rvalid_q   <= rst_in ? 1'b0 : rvalid_d;  // Only a cold reset drops a pending answer
    if (bank_rst) begin
      tone_q      <= `RST_TONE;
      pd_q        <= `RST_POWERDOWN;
      ext_q       <= `RST_EXT_STATUS;
      rate_q      <= `RST_RATE;
      vol_a_q     <= `RST_VOLUME;
      vol_b_q     <= `RST_VOLUME;
      link_shut_q <= 1'b0;
      hold_q      <= 8'h00;
      hold_addr_q <= 7'h00;
      hold_vld_q  <= 1'b0;
    end else begin
      tone_q      <= tone_d;
      pd_q        <= pd_d;
      ext_q       <= ext_d;
      rate_q      <= rate_d;
      vol_a_q     <= vol_a_d;
      vol_b_q     <= vol_b_d;
      link_shut_q <= link_shut_d;
      hold_q      <= hold_d;
      hold_addr_q <= hold_addr_d;
      hold_vld_q  <= hold_vld_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Derived controls: tone, power sequencing, rates

  // The DSP must finish its own shutdown before the clock is pulled
  always_comb begin
    pd_state_d   = pd_state_q;
    stop_d       = 1'b0;
    bass_d       = tone_gain(tone_q[`BASS_LSB +: 4]);
    treble_d     = tone_gain(tone_q[`TREBLE_LSB +: 4]);
    bass_byp_d   = tone_q[`BASS_LSB +: 4] == `TONE_BYPASS_CODE;
    treble_byp_d = tone_q[`TREBLE_LSB +: 4] == `TONE_BYPASS_CODE;
    eff_rate_d   = variable_rate_enable_out ?
                   (ext_q[`EXT_DRA_BIT] ? {rate_q, 1'b0} : {1'b0, rate_q}) :
                   {1'b0, `RATE_48K};
    unique case (pd_state_q)
      PD_RUN: begin
        if (pd_q[`PD_CLK_PD_BIT]) begin
          pd_state_d = PD_DSP;
        end
      end
      PD_DSP: begin
        if (!pd_q[`PD_CLK_PD_BIT]) begin
          pd_state_d = PD_RUN;
        end else if (dsp_pd_done_in) begin
          pd_state_d = PD_STOP;
          stop_d     = 1'b1;
        end
      end
      PD_STOP: begin
        stop_d = pd_q[`PD_CLK_PD_BIT];
        if (!pd_q[`PD_CLK_PD_BIT]) begin
          pd_state_d = PD_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (bank_rst) begin
      pd_state_q   <= PD_RUN;
      stop_q       <= 1'b0;
      bass_q       <= 5'sd0;
      treble_q     <= 5'sd0;
      bass_byp_q   <= 1'b1;
      treble_byp_q <= 1'b1;
      eff_rate_q   <= {1'b0, `RATE_48K};
    end else begin
      pd_state_q   <= pd_state_d;
      stop_q       <= stop_d;
      bass_q       <= bass_d;
      treble_q     <= treble_d;
      bass_byp_q   <= bass_byp_d;
      treble_byp_q <= treble_byp_d;
      eff_rate_q   <= eff_rate_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Additional channel volume, one slice per channel

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_chan
      logic [6:0] code, atten_q, atten_d;
      logic       mute_bit, mute_q, mute_d;
      assign code     = (ch < 2) ? ((ch == 0) ? vol_a_q[6:0] : vol_a_q[14:8])
                                 : ((ch == 2) ? vol_b_q[6:0] : vol_b_q[14:8]);
      assign mute_bit = (ch < 2) ? ((ch == 0) ? vol_a_q[`VOL_MUTE_LO_BIT] : vol_a_q[`VOL_MUTE_HI_BIT])
                                 : ((ch == 2) ? vol_b_q[`VOL_MUTE_LO_BIT] : vol_b_q[`VOL_MUTE_HI_BIT]);
      // Codes are attenuation only; top of the proprietary scale is silence
      always_comb begin
        atten_d = full_compliance_in ? (code & `VOL_FC_MASK) : code;
        mute_d  = mute_bit | (!full_compliance_in && code >= `VOL_PROP_MAX);
      end
      always_ff @(posedge clk_in) begin
        if (bank_rst) begin
          atten_q <= 7'h00;
          mute_q  <= 1'b1;
        end else begin
          atten_q <= atten_d;
          mute_q  <= mute_d;
        end
      end
      assign chan_atten_out[ch*7 +: 7] = atten_q;
      assign chan_mute_out[ch]         = mute_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop

  assign reg_rdata_out            = rdata_q;
  assign reg_rvalid_out           = rvalid_q;
  assign bass_gain_db_out         = bass_q;
  assign treble_gain_db_out       = treble_q;
  assign bass_bypass_out          = bass_byp_q;
  assign treble_bypass_out        = treble_byp_q;
  assign tone_channel_mask_out    = mask_q;
  assign link_hold_low_out        = link_shut_q;
  assign dsp_pd_req_out           = pd_q[`PD_CLK_PD_BIT];
  assign clk_stop_out             = stop_q;
  assign amp_fade_req_out         = pd_q[`PD_AMP_PD_BIT];
  assign variable_rate_enable_out = ext_q[`EXT_VRA_BIT];
  assign double_rate_enable_out   = ext_q[`EXT_DRA_BIT];
  assign sample_rate_out          = eff_rate_q;

  // Only the front pair carries tone processing; the mask is fixed, so reset needs no branch
  always_ff @(posedge clk_in) begin
    mask_q <= `TONE_CHANNEL_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_tone_reset_bypass: assert property (@(posedge clk_in) rst_in |=> tone_q == `RST_TONE && bass_byp_d)
    else $error("tone register not bypassed after reset");
  a_tone_dontcare_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    (tone_q & ~`TONE_VALID_MASK) == 16'h0000)
    else $error("tone don't-care bits not zero");
  a_pd_nibble_forced: assert property (@(posedge clk_in) disable iff (rst_in)
    commit && word_addr == `OFS_POWERDOWN |=> pd_q[3:0] == `PD_FORCED_NIBBLE)
    else $error("powerdown low nibble not forced");
  a_link_shut_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    link_shut_q && !warm_rst_in && !soft_rst |=> link_hold_low_out)
    else $error("link shutdown released without reset");
  a_clk_stop_order: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(clk_stop_out) |-> $past(pd_state_q == PD_DSP && dsp_pd_done_in))
    else $error("clock stopped before DSP sequence finished");
  a_ext_ready_bits: assert property (@(posedge clk_in) disable iff (rst_in)
    ext_q[9:6] == 4'b0111)
    else $error("readiness bits wrong");
  a_rate_rounding: assert property (@(posedge clk_in) disable iff (rst_in)
    commit && word_addr == `OFS_RATE_FRONT && !soft_rst && !warm_rst_in |=>
    rate_q == (($past(word_new) >= `RATE_MIDPOINT) ? `RATE_48K : `RATE_44K1))
    else $error("front rate not rounded");
  a_conv_rate_read: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == `OFS_RATE_CONV_A |=> reg_rdata_out == 8'hBB && reg_rvalid_out)
    else $error("converter rate not 48k");
  a_double_rate: assert property (@(posedge clk_in) disable iff (rst_in || warm_rst_in || soft_rst)
    variable_rate_enable_out && double_rate_enable_out |=> sample_rate_out == {$past(rate_q), 1'b0})
    else $error("double rate not applied");
  a_vol_reset_muted: assert property (@(posedge clk_in) rst_in |=> ##1 chan_mute_out == 4'hF)
    else $error("channels not muted after reset");

endmodule

// ===== audio_ctrl_regs.svh
// Register offsets, field positions, reset values and fixed codes of the audio control bank
`ifndef AUDIO_CTRL_REGS_SVH
`define AUDIO_CTRL_REGS_SVH

// Word offsets (high byte at the even address, low byte at the next odd one)
`define OFS_REG_RESET      8'h00
`define OFS_TONE           8'h08
`define OFS_POWERDOWN      8'h26
`define OFS_EXT_ID         8'h28
`define OFS_EXT_STATUS     8'h2A
`define OFS_RATE_FRONT     8'h2C
`define OFS_RATE_SURROUND  8'h2E
`define OFS_RATE_LFE       8'h30
`define OFS_RATE_CONV_A    8'h32
`define OFS_RATE_CONV_B    8'h34
`define OFS_VOL_CENTER_LFE 8'h36
`define OFS_VOL_REAR       8'h38

// Reset values
`define RST_TONE           16'h0F0F
`define RST_POWERDOWN      16'h800E
`define RST_EXT_STATUS     16'h01C0
`define RST_RATE           16'hBB80
`define RST_VOLUME         16'h8080

// Tone field layout
`define TONE_VALID_MASK    16'h0F0F
`define BASS_LSB           8
`define TREBLE_LSB         0
`define TONE_BYPASS_CODE   4'hF
`define BASS_CENTER_HZ     160
`define TREBLE_CENTER_HZ   5000
`define TONE_CHANNEL_MASK  6'h03

// Powerdown register fields
`define PD_LINK_SHUT_BIT   12
`define PD_CLK_PD_BIT      13
`define PD_AMP_PD_BIT      15
`define PD_FORCED_NIBBLE   4'hE

// Extended feature registers
`define EXT_ID_FIXED       16'h01C3
`define EXT_ID_SELECT_BIT  14
`define EXT_VRA_BIT        0
`define EXT_DRA_BIT        1
`define EXT_READY_MASK     16'h03C0
`define EXT_READY_VALUE    16'h01C0

// Sample rate codes
`define RATE_48K           16'hBB80
`define RATE_44K1          16'hAC44
`define RATE_MIDPOINT      16'hB3E2

// Volume fields
`define VOL_MUTE_HI_BIT    15
`define VOL_MUTE_LO_BIT    7
`define VOL_FC_MASK        7'h3F
`define VOL_PROP_MAX       7'h68

`endif

// ===== audio_ctrl_pkg.sv
// Types shared by the audio control register bank
package audio_ctrl_pkg;

  // Internal clock powerdown sequencing
  typedef enum logic [2:0] {
    PD_RUN  = 3'b001,
    PD_DSP  = 3'b010,
    PD_STOP = 3'b100
  } pd_state_t;

endpackage

// ===== reg_host_model.sv
// Register host model that drives the byte register port of the audio control bank
`timescale 1ns/1ps
module reg_host_model (
  // Clock
  input  wire logic       clk_in,
  // Byte register port
  output logic      [7:0] addr_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic      [7:0] wdata_out,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in
);
  // Idle values at time zero; no request until reset is released
  initial begin
    addr_out  = 8'h3E;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    wdata_out = 8'hA5;
  end

  // High byte at the even address first, the odd low byte commits the word
  task automatic write_word(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_out    <= 1'b1;
    addr_out  <= a & 8'hFE;
    wdata_out <= d[15:8];
    @(posedge clk_in);
    addr_out  <= a | 8'h01;
    wdata_out <= d[7:0];
    @(posedge clk_in);
    wr_out    <= 1'b0;
    wdata_out <= ~d[7:0]; // Released bus shows no stale byte
  endtask

  // Single byte strobe, for the pairing corner cases
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_out    <= 1'b1;
    addr_out  <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    wdata_out <= ~d;
  endtask

  // One read strobe; the answer is taken at the edge that samples valid high
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_out   <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_out <= 1'b0;
    @(posedge clk_in);
    d = (rvalid_in === 1'b1) ? rdata_in : 8'hXX; // No valid answer means no data
  endtask

  // Word read as high byte then low byte
  task automatic read_word(input logic [7:0] a, output logic [15:0] d);
    logic [7:0] h;
    logic [7:0] l;
    read_byte(a & 8'hFE, h);
    read_byte(a | 8'h01, l);
    d = {h, l};
  endtask
endmodule

// ===== tb.sv
// Self-checking testbench of the audio control register bank
`timescale 1ns/1ps
`include "audio_ctrl_regs.svh"
module tb;
  typedef struct packed { logic [7:0] a; logic [15:0] w; logic [15:0] r; } row_t;
  logic              clk_in;
  logic              rst_in;
  logic              warm_rst_in;
  logic       [7:0]  addr;
  logic              wr;
  logic              rd;
  logic       [7:0]  wdata;
  logic       [7:0]  rdata;
  logic              rvalid;
  logic              asel;
  logic              fc;
  logic              pd_done;
  logic       [4:0]  bass_gain;
  logic              bass_byp;
  logic       [4:0]  treble_gain;
  logic              treble_byp;
  logic       [5:0]  chmask;
  logic              link_hold;
  logic              pd_req;
  logic              clk_stop;
  logic              amp_fade;
  logic              variable_rate_enable;
  logic              double_rate_enable;
  logic       [16:0] rate;
  logic       [27:0] atten;
  logic       [3:0]  mute;
  logic       [15:0] rv;
  int                mismatches = 0;
  int                n_tests = 0;
  int                cycles = 0;
  // Gain per code 0..14 in signed whole dB
  logic [4:0] gains [15] = '{5'h0C, 5'h0A, 5'h08, 5'h06, 5'h04, 5'h02, 5'h01, 5'h00,
                             5'h1F, 5'h1E, 5'h1C, 5'h1A, 5'h18, 5'h16, 5'h14};
  // Write, then read back: address, written word, expected word
  row_t rows [15] = '{
    '{8'h08, 16'h0305, 16'h0305}, '{8'h08, 16'hFFFF, 16'h0F0F}, '{8'h26, 16'h8001, 16'h800E},
    '{8'h28, 16'h0000, 16'h01C3}, '{8'h2A, 16'hFFFF, 16'hFDFF}, '{8'h2C, 16'hAC44, 16'hAC44},
    '{8'h2E, 16'h1234, 16'hAC44}, '{8'h30, 16'h0000, 16'hAC44}, '{8'h2C, 16'hB3E2, 16'hBB80},
    '{8'h2C, 16'hB3E1, 16'hAC44}, '{8'h2C, 16'h0000, 16'hAC44}, '{8'h2C, 16'hFFFF, 16'hBB80},
    '{8'h32, 16'hAC44, 16'hBB80}, '{8'h36, 16'h1F05, 16'h1F05}, '{8'h3A, 16'h1234, 16'h0000}};
  // Default words after any reset
  row_t rst_rows [10] = '{
    '{8'h08, 16'h0, 16'h0F0F}, '{8'h26, 16'h0, 16'h800E}, '{8'h2A, 16'h0, 16'h01C0},
    '{8'h2C, 16'h0, 16'hBB80}, '{8'h2E, 16'h0, 16'hBB80}, '{8'h30, 16'h0, 16'hBB80},
    '{8'h32, 16'h0, 16'hBB80}, '{8'h34, 16'h0, 16'hBB80}, '{8'h36, 16'h0, 16'h8080},
    '{8'h38, 16'h0, 16'h8080}};

  ////////////////////////////////////////////////////////////////////////////////
  // Design and host
  audio_ctrl_bank dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .warm_rst_in(warm_rst_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .address_select_pin_in(asel), .full_compliance_in(fc), .dsp_pd_done_in(pd_done),
    .bass_gain_db_out(bass_gain), .bass_bypass_out(bass_byp),
    .treble_gain_db_out(treble_gain), .treble_bypass_out(treble_byp),
    .tone_channel_mask_out(chmask), .link_hold_low_out(link_hold), .dsp_pd_req_out(pd_req),
    .clk_stop_out(clk_stop), .amp_fade_req_out(amp_fade), .variable_rate_enable_out(variable_rate_enable),
    .double_rate_enable_out(double_rate_enable), .sample_rate_out(rate), .chan_atten_out(atten),
    .chan_mute_out(mute));
  reg_host_model host_u (
    .clk_in(clk_in), .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata),
    .rdata_in(rdata), .rvalid_in(rvalid));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling so a hang still ends in the verdict
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Derived outputs trail the register by one edge, so three edges are plenty
  task automatic settle();
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  task automatic reset_table();
    settle();
    for (int i = 0; i < 10; i++) begin
      host_u.read_word(rst_rows[i].a, rv);
      check(rv, rst_rows[i].r);
    end
    check({bass_byp, treble_byp, amp_fade, link_hold}, 4'hE);
    check({chmask, mute, rate}, {6'h03, 4'hF, 17'h0BB80});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_in      = 1'b1;
    warm_rst_in = 1'b0;
    asel        = 1'b0;
    fc          = 1'b0;
    pd_done     = 1'b0;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    reset_table();
    for (int i = 0; i < 15; i++) begin
      host_u.write_word(rows[i].a, rows[i].w);
      host_u.read_word(rows[i].a, rv);
      check(rv, rows[i].r);
    end
    // Every tone code on both bands
    for (int c = 0; c < 16; c++) begin
      host_u.write_word(`OFS_TONE, {4'h0, 4'(c), 4'h0, 4'(15 - c)});
      settle();
      check({bass_byp, treble_byp}, {c == 15, c == 0});
      if (c < 15) check(bass_gain, gains[c]);
      if (c > 0) check(treble_gain, gains[15 - c]);
    end
    // Effective rate follows the enables
    host_u.write_word(`OFS_EXT_STATUS, 16'h0000);
    host_u.write_word(`OFS_RATE_FRONT, 16'hAC44);
    settle();
    check(rate, 17'h0BB80);
    host_u.write_word(`OFS_EXT_STATUS, 16'h0001);
    settle();
    check({variable_rate_enable, rate}, {1'b1, 17'h0AC44});
    host_u.write_word(`OFS_EXT_STATUS, 16'h0003);
    settle();
    check({double_rate_enable, rate}, {1'b1, 17'h15888});
    // Identity bit follows the select pin through its synchroniser
    @(posedge clk_in);
    asel <= 1'b1;
    settle();
    host_u.read_word(`OFS_EXT_ID, rv);
    check(rv, 16'h41C3);
    // Channel volumes and mutes
    host_u.write_word(`OFS_VOL_CENTER_LFE, 16'h2A15);
    host_u.write_word(`OFS_VOL_REAR, 16'h8133);
    settle();
    check({atten, mute}, {7'h01, 7'h33, 7'h2A, 7'h15, 4'h8});
    host_u.write_word(`OFS_VOL_CENTER_LFE, 16'h0068);
    settle();
    check(mute[0], 1'b1);
    @(posedge clk_in);
    fc <= 1'b1;
    settle();
    check(mute[0], 1'b0);
    check(atten[6:0], 7'h28);
    // Clock stop waits for the processor, amplifier request tracks bit 15
    host_u.write_word(`OFS_POWERDOWN, 16'hA000);
    settle();
    check({pd_req, clk_stop, amp_fade}, 3'h5);
    @(posedge clk_in);
    pd_done <= 1'b1;
    settle();
    check(clk_stop, 1'b1);
    host_u.write_word(`OFS_POWERDOWN, 16'h0000);
    settle();
    check({clk_stop, amp_fade}, 2'h0);
    @(posedge clk_in);
    pd_done <= 1'b0;
    // Link shutdown latches until a reset
    host_u.write_word(`OFS_POWERDOWN, 16'h1000);
    host_u.write_word(`OFS_POWERDOWN, 16'h0000);
    settle();
    host_u.read_word(`OFS_POWERDOWN, rv);
    check({link_hold, rv}, {1'b1, 16'h100E});
    host_u.write_word(`OFS_REG_RESET, 16'h0000);
    reset_table();
    // Warm reset restores defaults too
    host_u.write_word(`OFS_TONE, 16'h0102);
    @(posedge clk_in);
    warm_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    warm_rst_in <= 1'b0;
    reset_table();
    // Lone low byte keeps the present high byte; a lone high byte never commits
    host_u.write_byte(`OFS_TONE | 8'h01, 8'h03);
    host_u.write_byte(`OFS_TONE, 8'h05);
    host_u.read_word(`OFS_TONE, rv);
    check(rv, 16'h0F03);
    host_u.write_byte(`OFS_VOL_REAR | 8'h01, 8'h11);
    host_u.read_word(`OFS_VOL_REAR, rv);
    check(rv, 16'h8011);
    wrap_up();
  end
endmodule
